// ### design/dispbuf_pkg.sv
// Package: constants and carriers for the display buffer access block
package dispbuf_pkg;
    localparam int          ADDR_W          = 14;          // Display address width, 16k locations
    localparam logic [1:0]  MODE_INDEP      = 2'h0;        // Buffer mode encodings
    localparam logic [1:0]  MODE_TRANSP     = 2'h1;
    localparam logic [1:0]  MODE_SHARED     = 2'h2;
    localparam logic [1:0]  MODE_ROWBUF     = 2'h3;
    localparam int          BIT_INTERLACE   = 3;           // Control flag positions on the address bus
    localparam int          BIT_LINE_LO     = 4;
    localparam int          BIT_FIRST_LINE  = 6;
    localparam int          BIT_PEN_LINE    = 9;
    localparam int          BIT_UNDERSCORE  = 10;
    localparam int          BIT_BLINK       = 11;
    localparam int          BIT_ODD_FIELD   = 12;
    localparam int          BIT_FINAL_LINE  = 13;
    localparam logic [3:0]  PEN_LINE_BASE   = 4'h3;        // Pen line = 3 + 2*code
    localparam int          SETUP_NS        = 1000;        // Immediate execution setup time
    localparam int          CLK_NS          = 100;         // Clock period
    localparam int          SETUP_CYC       = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic        STROBE_IDLE     = 1'b1;        // Active-low strobes idle high
    localparam logic [ADDR_W-1:0] ADDR_RST  = 14'h0000;

    // Buffer commands
    typedef enum logic [2:0]
    {
        CMD_RD_PTR    = 3'h0,
        CMD_WR_PTR    = 3'h1,
        CMD_RD_CUR    = 3'h2,
        CMD_WR_CUR    = 3'h3,
        CMD_RD_CUR_I  = 3'h4,
        CMD_WR_CUR_I  = 3'h5,
        CMD_FILL      = 3'h6,
        CMD_NONE      = 3'h7
    } buf_cmd_t;

    // Per-line raster state from the timing section
    typedef struct packed
    {
        logic [3:0] scan_line_number;   // Line within row
        logic       row_first_line;     // Coming line is first of row
        logic       row_final_line;     // Coming line is last of row
        logic       odd_row;            // Current character row is odd
        logic       odd_field;          // Odd field in progress
        logic       vsync_pulse;        // One pulse per vertical sync
    } raster_t;

    // Configuration fields
    typedef struct packed
    {
        logic [1:0] buffer_mode;        // Independent, transparent, shared, row
        logic       interlace_en;       // Interlace on
        logic       sync_video;         // Interlaced sync-and-video format
        logic [1:0] pen_line_sel;       // Light pen line code
        logic [3:0] underscore_pos;     // Underline scan line
        logic       blink_slow;         // Blink 1/32 instead of 1/16
    } config_t;
endpackage

// ### design/display_buffer_independent_access.sv
// Display address output and independent-mode buffer access sequencer
// Summary of operation
// - Drive fourteen-bit display address bus
// - Float address outputs depending on buffer mode
// - Multiplex line flags on bits 3-13 in blanking
// - Bit 3 carries interlace line parity
// - Bits 4, 5 and 7 carry scan line number bits 0, 1 and 3
// - Bit 6 flags first line of row
// - Bit 9 flags programmed light pen line
// - Bit 10 flags programmed underline line
// - Bit 11 blinks at divided vsync rate
// - Bit 12 flags odd field when interlaced
// - Bit 13 flags last line of row
// - Access at cursor or pointer address, or between them for fill
// - Transfers happen only during blanking
// - Write strobe low for one clock period
// - Chip select drops for one clock before each write
// - Accept pointer, cursor, increment and fill commands
// - Set done flag after each command; a fill sets it once at its end
// - Done pulse usable as ready interrupt source
// - Fill writes latch value cursor through pointer
// - Active-window commands other than fill wait; vblank or display-off ones run now
// - Fill forces blank until next retrace
// - Two-bit mode field selects configuration
// - Handshake pins become write, read, select
`timescale 1ns/1ps
module display_buffer_independent_access
#(
    parameter int SETUP_CYCLES = dispbuf_pkg::SETUP_CYC     // Immediate execution setup count
)
(
    input  wire logic                              CLK,
    input  wire logic                              RESET,
    input  wire dispbuf_pkg::config_t              CONFIG,          // Configuration fields
    input  wire dispbuf_pkg::raster_t              RASTER,          // Raster line state
    input  wire logic [dispbuf_pkg::ADDR_W-1:0]    REFRESH_ADDR,    // Address for active display
    input  wire logic                              HBLANK,          // Horizontal blanking
    input  wire logic                              VBLANK,          // Vertical blanking
    input  wire logic                              DISPLAY_OFF,     // Display commanded blank
    input  wire logic                              HRETRACE,        // Horizontal retrace pulse
    input  wire logic                              FLOAT_CMD,       // Float address command
    input  wire logic [dispbuf_pkg::ADDR_W-1:0]    CURSOR_ADDR,     // Cursor register value
    input  wire logic                              CURSOR_LOAD,     // Load cursor register
    input  wire logic [dispbuf_pkg::ADDR_W-1:0]    POINTER_ADDR,    // Pointer register value
    input  wire logic                              POINTER_LOAD,    // Load pointer register
    input  wire dispbuf_pkg::buf_cmd_t             CMD,             // Buffer command
    input  wire logic                              CMD_VALID,       // Command strobe
    output logic [dispbuf_pkg::ADDR_W-1:0]         DISPLAY_ADDR_BUS,
    output logic                                   DISPLAY_ADDR_OE, // High while bus driven
    output logic                                   BUFFER_WRITE_STROBE_N,
    output logic                                   BUFFER_READ_STROBE_N,
    output logic                                   BUFFER_CHIP_SELECT_N,
    output logic                                   LATCH_CAPTURE,   // Latch takes memory data
    output logic                                   BLANK,           // Blank output incl. forced
    output logic                                   TRANSFER_DONE_FLAG,
    output logic                                   READY_EVENT,     // One-cycle completion pulse
    output logic [dispbuf_pkg::ADDR_W-1:0]         CURSOR_Q         // Cursor register readback
);
    import dispbuf_pkg::*;

    // Elaboration check: the setup counter is four bits wide
    if (SETUP_CYCLES < 1 || SETUP_CYCLES > 15)
    begin : g_setup_chk
        $error("SETUP_CYCLES out of range");
    end

    // Sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'h0,
        ST_WAIT   = 3'h1,
        ST_SETUP  = 3'h2,
        ST_DESEL  = 3'h3,
        ST_STROBE = 3'h4,
        ST_FINISH = 3'h5
    } seq_state_t;

    seq_state_t          state_r;          // Sequencer state
    buf_cmd_t            cmd_r;            // Command in progress
    logic [ADDR_W-1:0]   cursor_r;         // Cursor address register
    logic [ADDR_W-1:0]   pointer_r;        // Pointer address register
    logic [ADDR_W-1:0]   xfer_addr_r;      // Address of current transfer
    logic [3:0]          setup_cnt_r;      // Setup delay counter
    logic [4:0]          blink_div_r;      // Vertical sync divider
    logic                fill_blank_r;     // Forced blank during fill
    logic                fill_done_r;      // Fill finished, await retrace
    logic                in_blank;         // Any blanking in effect
    logic                is_write;         // Command writes memory
    logic                is_fill;          // Command is a block fill
    logic                independent;      // Independent mode selected
    logic [ADDR_W-1:0]   flags;            // Multiplexed control word
    logic [3:0]          pen_line;         // Programmed pen line

    assign independent = (CONFIG.buffer_mode == MODE_INDEP);
    assign in_blank    = HBLANK || VBLANK || DISPLAY_OFF || fill_blank_r;
    assign is_write    = (cmd_r == CMD_WR_PTR) || (cmd_r == CMD_WR_CUR) ||
                         (cmd_r == CMD_WR_CUR_I) || (cmd_r == CMD_FILL);
    assign is_fill     = (cmd_r == CMD_FILL);
    assign pen_line    = PEN_LINE_BASE + {1'b0, CONFIG.pen_line_sel, 1'b0};

    // Flags for the coming line
    always_comb
    begin
        flags = ADDR_RST;
        flags[BIT_LINE_LO +: 4] = RASTER.scan_line_number;
        if (CONFIG.interlace_en && CONFIG.sync_video)
        begin
            // Low for even row/even field or odd row/odd field
            flags[BIT_INTERLACE] = ~(RASTER.odd_row ^ ~RASTER.odd_field);
        end
        flags[BIT_FIRST_LINE] = RASTER.row_first_line;
        flags[BIT_PEN_LINE]   = (RASTER.scan_line_number == pen_line);
        flags[BIT_UNDERSCORE] = (RASTER.scan_line_number == CONFIG.underscore_pos);
        flags[BIT_BLINK]      = CONFIG.blink_slow ? blink_div_r[4] : blink_div_r[3];
        flags[BIT_ODD_FIELD]  = CONFIG.interlace_en && RASTER.odd_field;
        flags[BIT_FINAL_LINE] = RASTER.row_final_line;
    end

    // Blink divider counts vertical syncs
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            blink_div_r <= 5'h00;
        else if (RASTER.vsync_pulse)
            blink_div_r <= blink_div_r + 5'h01;
    end

    // Pointer register, loaded by software
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            pointer_r <= ADDR_RST;
        else if (POINTER_LOAD)
            pointer_r <= POINTER_ADDR;
    end

    // Cursor; software load beats increment
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            cursor_r <= ADDR_RST;
        else if (CURSOR_LOAD)
            cursor_r <= CURSOR_ADDR;
        else if (state_r == ST_FINISH &&
                 (cmd_r == CMD_RD_CUR_I || cmd_r == CMD_WR_CUR_I))
            cursor_r <= cursor_r + 14'h0001;
    end

    // Command sequencer
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state_r     <= ST_IDLE;
            cmd_r       <= CMD_NONE;
            xfer_addr_r <= ADDR_RST;
            setup_cnt_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    // Commands outside independent mode are ignored
                    if (CMD_VALID && independent && CMD != CMD_NONE)
                    begin
                        cmd_r <= CMD;
                        // Cursor or pointer as named
                        xfer_addr_r <= (CMD == CMD_RD_PTR || CMD == CMD_WR_PTR) ?
                                       pointer_r : cursor_r;
                        setup_cnt_r <= SETUP_CYCLES[3:0];
                        // Vblank, display off or fill: run at once; else wait for next blank
                        if (VBLANK || DISPLAY_OFF || CMD == CMD_FILL)
                            state_r <= ST_SETUP;
                        else
                            state_r <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (HBLANK || VBLANK || DISPLAY_OFF)
                    begin
                        setup_cnt_r <= 4'h1;
                        state_r     <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    // About one microsecond of setup when run at once; one clock after ST_WAIT
                    if (setup_cnt_r <= 4'h1)
                        state_r <= is_write ? ST_DESEL : ST_STROBE;
                    else
                        setup_cnt_r <= setup_cnt_r - 4'h1;
                end
                ST_DESEL:
                    state_r <= ST_STROBE;
                ST_STROBE:
                begin
                    if (!in_blank)
                        state_r <= ST_WAIT;
                    else if (is_fill && xfer_addr_r != pointer_r)
                    begin
                        xfer_addr_r <= xfer_addr_r + 14'h0001;
                        state_r     <= ST_DESEL;
                    end
                    else
                        state_r <= ST_FINISH;
                end
                ST_FINISH:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Strobes and chip select
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            BUFFER_WRITE_STROBE_N <= STROBE_IDLE;
            BUFFER_READ_STROBE_N  <= STROBE_IDLE;
            BUFFER_CHIP_SELECT_N  <= STROBE_IDLE;
            LATCH_CAPTURE         <= 1'b0;
        end
        else
        begin
            // Next-state strobe: low exactly one period in ST_STROBE
            // Fill steps also pass through ST_DESEL, so one term serves both
            BUFFER_WRITE_STROBE_N <= ~(independent && is_write &&
                                     state_r == ST_DESEL);
            BUFFER_READ_STROBE_N  <= ~(independent && !is_write &&
                                     state_r == ST_SETUP && setup_cnt_r <= 4'h1);
            // Select idles active in independent mode, else held inactive
            BUFFER_CHIP_SELECT_N  <= ~independent ||
                                     (is_write && state_r == ST_SETUP && setup_cnt_r <= 4'h1) ||
                                     (is_write && state_r == ST_STROBE && is_fill &&
                                      in_blank && xfer_addr_r != pointer_r);
            LATCH_CAPTURE         <= (state_r == ST_STROBE) && !is_write;
        end
    end

    // Address bus source
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            DISPLAY_ADDR_BUS <= ADDR_RST;
            DISPLAY_ADDR_OE  <= 1'b0;
        end
        else
        begin
            if (state_r == ST_SETUP || state_r == ST_DESEL || state_r == ST_STROBE)
                DISPLAY_ADDR_BUS <= xfer_addr_r;
            else if (in_blank)
                DISPLAY_ADDR_BUS <= flags;
            else
                DISPLAY_ADDR_BUS <= REFRESH_ADDR;
            // Floated on request or in row buffer mode
            DISPLAY_ADDR_OE  <= !(FLOAT_CMD || CONFIG.buffer_mode == MODE_ROWBUF);
        end
    end

    // Forced blank during fill
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            fill_blank_r <= 1'b0;
            fill_done_r  <= 1'b0;
        end
        else if (state_r == ST_IDLE && CMD_VALID && independent && CMD == CMD_FILL)
        begin
            fill_blank_r <= 1'b1;
            fill_done_r  <= 1'b0;
        end
        else if (state_r == ST_FINISH && is_fill)
            fill_done_r <= 1'b1;
        else if (fill_done_r && HRETRACE)
        begin
            fill_blank_r <= 1'b0;
            fill_done_r  <= 1'b0;
        end
    end

    // Blank output and completion flag
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            BLANK              <= 1'b1;
            TRANSFER_DONE_FLAG <= 1'b1;
            READY_EVENT        <= 1'b0;
            CURSOR_Q           <= ADDR_RST;
        end
        else
        begin
            BLANK       <= in_blank;
            READY_EVENT <= (state_r == ST_FINISH);
            CURSOR_Q    <= cursor_r;
            // Completion wins over a new command in the same cycle
            if (state_r == ST_FINISH)
                TRANSFER_DONE_FLAG <= 1'b1;
            else if (state_r == ST_IDLE && CMD_VALID && independent && CMD != CMD_NONE)
                TRANSFER_DONE_FLAG <= 1'b0;
        end
    end
endmodule

// ### bench/dispbuf_ram_model.sv
// Partner model: display buffer RAM behind the CPU-side interface latch
`timescale 1ns/1ps
module dispbuf_ram_model
(
    input  wire logic        clk,
    input  wire logic [13:0] addr,    // Display address bus
    input  wire logic        wr_n,    // Write strobe, low active
    input  wire logic        rd_n,    // Read strobe, low active
    input  wire logic        cs_n,    // Chip select, low active
    input  wire logic        capture, // Latch takes the data lines
    input  wire logic        load,    // CPU loads the latch
    input  wire logic [7:0]  din,     // CPU data for the latch
    output logic      [7:0]  latch_q, // Interface latch
    output logic      [7:0]  data_q   // RAM data lines seen by the latch
);
    logic [7:0] mem [16384];          // Whole 16k space

    // Write on selected strobe
    always_ff @(posedge clk)
        if (!wr_n && !cs_n)
            mem[addr] <= latch_q;

    // Data valid one cycle after read strobe, then garbage
    always_ff @(posedge clk)
        data_q <= (!rd_n && !cs_n) ? mem[addr] : ~data_q;

    // CPU load wins over capture
    always_ff @(posedge clk)
        if (load)
            latch_q <= din;
        else if (capture)
            latch_q <= data_q;
endmodule

// ### bench/display_buffer_independent_access_props.sv
// Checker: port-level timing of the display buffer access block
`timescale 1ns/1ps
module dispbuf_props
#(
    parameter int SETUP_CYCLES = dispbuf_pkg::SETUP_CYC  // Same setup count as the block
)
(
    input wire logic                  CLK,
    input wire logic                  RESET,
    input wire dispbuf_pkg::config_t  CONFIG,
    input wire dispbuf_pkg::raster_t  RASTER,
    input wire logic                  HBLANK,
    input wire logic                  VBLANK,
    input wire logic                  DISPLAY_OFF,
    input wire logic                  FLOAT_CMD,
    input wire dispbuf_pkg::buf_cmd_t CMD,
    input wire logic                  CMD_VALID,
    input wire logic [13:0]           DISPLAY_ADDR_BUS,
    input wire logic                  DISPLAY_ADDR_OE,
    input wire logic                  BUFFER_WRITE_STROBE_N,
    input wire logic                  BUFFER_READ_STROBE_N,
    input wire logic                  BUFFER_CHIP_SELECT_N,
    input wire logic                  LATCH_CAPTURE,
    input wire logic                  BLANK,
    input wire logic                  TRANSFER_DONE_FLAG,
    input wire logic                  READY_EVENT
);
    import dispbuf_pkg::*;
    localparam int LAT_MAX = SETUP_CYCLES + 8;  // Longest immediate single transfer
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    a_wr_one_cycle: assert property ($fell(BUFFER_WRITE_STROBE_N) |=> BUFFER_WRITE_STROBE_N)
        else $error("write strobe longer than one clock");
    a_wr_with_sel: assert property (!BUFFER_WRITE_STROBE_N |-> !BUFFER_CHIP_SELECT_N)
        else $error("write strobe without chip select");
    a_sel_gap: assert property ($fell(BUFFER_WRITE_STROBE_N) |-> $past(BUFFER_CHIP_SELECT_N))
        else $error("chip select did not drop before write");
    a_rd_capture: assert property ($fell(BUFFER_READ_STROBE_N) |=> BUFFER_READ_STROBE_N && LATCH_CAPTURE)
        else $error("read strobe length or capture wrong");
    a_rd_with_sel: assert property (!BUFFER_READ_STROBE_N |-> !BUFFER_CHIP_SELECT_N)
        else $error("read strobe without chip select");
    a_xfer_blanked: assert property (!BUFFER_WRITE_STROBE_N || !BUFFER_READ_STROBE_N
        |-> HBLANK || VBLANK || DISPLAY_OFF || BLANK)
        else $error("transfer outside blanking");
    a_busy_strobe: assert property (!BUFFER_WRITE_STROBE_N || !BUFFER_READ_STROBE_N |-> !TRANSFER_DONE_FLAG)
        else $error("strobe while done flag set");
    a_done_event: assert property ($rose(TRANSFER_DONE_FLAG) |-> READY_EVENT)
        else $error("completion without ready pulse");
    a_float_mode: assert property ((CONFIG.buffer_mode == MODE_ROWBUF || FLOAT_CMD)[*2] |-> !DISPLAY_ADDR_OE)
        else $error("address bus driven while floated");
    a_fast_op: assert property (CMD_VALID && TRANSFER_DONE_FLAG && CONFIG.buffer_mode == MODE_INDEP && VBLANK
        && CMD != CMD_FILL && CMD != CMD_NONE |=> !TRANSFER_DONE_FLAG ##[1:LAT_MAX] TRANSFER_DONE_FLAG)
        else $error("immediate transfer too slow");
    a_final_flag: assert property ((HBLANK && TRANSFER_DONE_FLAG && $stable(RASTER)
        && CONFIG.buffer_mode == MODE_INDEP)[*3] |-> DISPLAY_ADDR_BUS[13] == RASTER.row_final_line)
        else $error("last line flag wrong");

    c_write: cover property ($fell(BUFFER_WRITE_STROBE_N));
    c_read: cover property (LATCH_CAPTURE);
    c_fill: cover property (BLANK && !VBLANK && !HBLANK && !TRANSFER_DONE_FLAG);
endmodule

bind display_buffer_independent_access dispbuf_props #(.SETUP_CYCLES(SETUP_CYCLES)) props (.*);

// ### bench/display_buffer_independent_access_test.sv
// Testbench: transfers, fill, refusals and flag words
`timescale 1ns/1ps
module display_buffer_independent_access_test;
    import dispbuf_pkg::*;
    typedef struct packed {logic [1:0] kind; logic [13:0] a; logic [7:0] d;} note_t; // Expected event
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    config_t     CONFIG;
    raster_t     RASTER;
    buf_cmd_t    CMD;
    logic [13:0] REFRESH_ADDR, CURSOR_ADDR, POINTER_ADDR, DISPLAY_ADDR_BUS, CURSOR_Q, rd_a, c, p, a;
    logic        HBLANK, VBLANK, DISPLAY_OFF, HRETRACE, FLOAT_CMD, CURSOR_LOAD, POINTER_LOAD, CMD_VALID;
    logic        DISPLAY_ADDR_OE, BUFFER_WRITE_STROBE_N, BUFFER_READ_STROBE_N, BUFFER_CHIP_SELECT_N;
    logic        LATCH_CAPTURE, BLANK, TRANSFER_DONE_FLAG, READY_EVENT, lload, probe;
    logic [7:0]  ldin, latch_q, data_q, d;
    logic [7:0]  exp_mem [16384];   // Expected RAM
    note_t       q [$];             // Expected events, oldest first
    int          n_fail = 0, checked = 0, cyc = 0, seed = 32'hc44eda1d;
    buf_cmd_t    ops [6] = '{CMD_WR_PTR, CMD_RD_CUR_I, CMD_WR_CUR_I, CMD_RD_PTR, CMD_WR_CUR, CMD_RD_CUR};

    always #50 CLK = ~CLK;          // 10 MHz character clock

    // Short setup keeps runs brief
    display_buffer_independent_access #(.SETUP_CYCLES(2)) uut (.*);
    dispbuf_ram_model ram (.clk(CLK), .addr(DISPLAY_ADDR_BUS), .wr_n(BUFFER_WRITE_STROBE_N),
        .rd_n(BUFFER_READ_STROBE_N), .cs_n(BUFFER_CHIP_SELECT_N), .capture(LATCH_CAPTURE),
        .load(lload), .din(ldin), .latch_q(latch_q), .data_q(data_q));

    task automatic cmp_val(string nm, logic [13:0] e, logic [13:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_flag(string nm, logic e, logic g);
        cmp_val(nm, 14'(e), 14'(g));
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    // Oldest note per result
    always @(posedge CLK)
    begin
        note_t n;
        if (!BUFFER_READ_STROBE_N)
            rd_a = DISPLAY_ADDR_BUS;
        if (!RESET && (BUFFER_WRITE_STROBE_N === 1'b0 || LATCH_CAPTURE === 1'b1 || probe))
        begin
            n = (q.size() > 0) ? q.pop_front() : '1;
            cmp_val("event kind", n.kind, !BUFFER_WRITE_STROBE_N ? 0 : LATCH_CAPTURE ? 1 : 2);
            if (n.kind == 2'h0)
            begin
                cmp_val("write address", n.a, DISPLAY_ADDR_BUS);
                cmp_val("write data", n.d, latch_q);
            end
            else if (n.kind == 2'h1)
            begin
                cmp_val("read address", n.a, rd_a);
                cmp_val("read data", n.d, data_q);
            end
            else
                cmp_val("flag word", n.a, DISPLAY_ADDR_BUS & (n.d[0] ? 14'h3608 : 14'h36B0));
        end
    end

    task automatic tick(int n);
        repeat (n) @(negedge CLK);
    endtask

    // CPU loads before a command
    task automatic load(logic [13:0] cv, logic [13:0] pv, logic [7:0] dv);
        CURSOR_ADDR = cv;
        POINTER_ADDR = pv;
        ldin = dv;
        {CURSOR_LOAD, POINTER_LOAD, lload} = 3'h7;
        tick(1);
        {CURSOR_LOAD, POINTER_LOAD, lload} = 3'h0;
    endtask

    // One command, maybe a second while busy
    task automatic run(buf_cmd_t cm, bit twice);
        int k = 0;
        CMD = cm;
        CMD_VALID = 1'b1;
        tick(1);
        CMD = CMD_WR_CUR;
        if (twice)
            tick(1);
        CMD_VALID = 1'b0;
        if (!VBLANK && !DISPLAY_OFF)
        begin
            tick(15);
            cmp_flag("done in active window", 1'b0, TRANSFER_DONE_FLAG);
            HBLANK = 1'b1;
        end
        while (TRANSFER_DONE_FLAG !== 1'b1 && k < 500)
        begin
            tick(1);
            k++;
        end
        cmp_flag("done flag", 1'b1, TRANSFER_DONE_FLAG);
        HBLANK = 1'b0;
        tick(1);
    endtask

    // Expected flag word, masked per format
    function automatic logic [13:0] flags();
        logic [13:0] w;
        w = '0;
        w[3] = RASTER.odd_row ^ RASTER.odd_field;
        w[7:4] = RASTER.scan_line_number;
        w[9] = RASTER.scan_line_number == PEN_LINE_BASE + {CONFIG.pen_line_sel, 1'b0};
        w[10] = RASTER.scan_line_number == CONFIG.underscore_pos;
        w[12] = CONFIG.interlace_en & RASTER.odd_field;
        w[13] = RASTER.row_final_line;
        return w & (CONFIG.sync_video ? 14'h3608 : 14'h36B0);
    endfunction

    initial
    begin
        CONFIG = '0;
        RASTER = '0;
        {REFRESH_ADDR, CURSOR_ADDR, POINTER_ADDR, ldin} = '0;
        {HBLANK, VBLANK, DISPLAY_OFF, HRETRACE, FLOAT_CMD, CURSOR_LOAD, POINTER_LOAD, CMD_VALID, lload, probe} = '0;
        CMD = CMD_NONE;
        tick(6);
        cmp_flag("done at reset", 1'b1, TRANSFER_DONE_FLAG);
        RESET = 1'b0;
        tick(3);
        $display("test reset done");
        // Singles: vblank, active, display off
        for (int pass = 0; pass < 3; pass++)
        begin
            VBLANK = (pass == 0);
            DISPLAY_OFF = (pass == 2);
            foreach (ops[i])
            begin
                REFRESH_ADDR = $random(seed);
                d = $random(seed);
                c = ops[i][0] ? 14'($random(seed)) : a;
                p = ops[i][0] ? 14'($random(seed)) : a;
                a = (ops[i][2:1] == 2'h0) ? p : c;
                load(c, p, d);
                if (ops[i][0])
                    exp_mem[a] = d;
                q.push_back({ops[i][0] ? 2'h0 : 2'h1, a, exp_mem[a]});
                run(ops[i], 1'b0);
                cmp_val("cursor", c + 14'(ops[i] == CMD_RD_CUR_I || ops[i] == CMD_WR_CUR_I), CURSOR_Q);
            end
            $display("test singles pass %0d done", pass);
        end
        // Fill four locations; blank held to retrace
        DISPLAY_OFF = 1'b0;
        VBLANK = 1'b1;
        c = 14'($random(seed)) & 14'h3FF0;
        d = $random(seed);
        load(c, c + 14'h3, d);
        for (int k = 0; k < 4; k++)
            q.push_back({2'h0, c + 14'(k), d});
        run(CMD_FILL, 1'b0);
        cmp_val("cursor after fill", c, CURSOR_Q);
        VBLANK = 1'b0;
        tick(3);
        cmp_flag("blank held after fill", 1'b1, BLANK);
        HRETRACE = 1'b1;
        tick(1);
        HRETRACE = 1'b0;
        tick(3);
        cmp_flag("blank after retrace", 1'b0, BLANK);
        $display("test fill done");
        // Other modes ignored; second command while busy too
        for (int m = 1; m < 4; m++)
        begin
            CONFIG.buffer_mode = m;
            CMD = CMD_WR_PTR;
            CMD_VALID = 1'b1;
            tick(1);
            CMD_VALID = 1'b0;
            tick(2);
            cmp_flag("done in other mode", 1'b1, TRANSFER_DONE_FLAG);
            cmp_flag("bus drive", m != 3, DISPLAY_ADDR_OE);
        end
        CONFIG.buffer_mode = MODE_INDEP;
        VBLANK = 1'b1;
        load(14'h0010, 14'h3FFF, 8'hA5);
        q.push_back({2'h0, 14'h3FFF, 8'hA5});
        run(CMD_WR_PTR, 1'b1);
        FLOAT_CMD = 1'b1;
        tick(3);
        cmp_flag("bus drive when floated", 1'b0, DISPLAY_ADDR_OE);
        FLOAT_CMD = 1'b0;
        VBLANK = 1'b0;
        $display("test refusals done");
        // Flag words over all scan lines
        HBLANK = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            RASTER = $random(seed);
            RASTER.scan_line_number = i;
            RASTER.vsync_pulse = 1'b0;
            CONFIG = $random(seed);
            CONFIG.buffer_mode = MODE_INDEP;
            CONFIG.sync_video = i[0];
            CONFIG.interlace_en = CONFIG.interlace_en | i[0];
            if (i[1])
                CONFIG.underscore_pos = i;
            tick(4);
            q.push_back({2'h2, flags(), 7'h0, i[0]});
            probe = 1'b1;
            tick(1);
            probe = 1'b0;
        end
        HBLANK = 1'b0;
        $display("test flag words done");
        tally_and_finish();
    end
endmodule
